/* File: add_bus_mux_pkg.sv */
/*
  constants for the shared add-bus / line-input pin block: register
  addresses, field positions, reset values, lane map and buffer sizes.
  assumes nothing of its surroundings.
*/
package add_bus_mux_pkg;
  localparam int N_LINE = 3;
  localparam int BYTE_W = 8;
  // direct addresses of the i/o control registers, line channels 0, 4, 8
  localparam logic [2:0][15:0] IO_CTRL_DIRECT =
    {16'h9f01, 16'h5f01, 16'h1f01};
  // indirect page and offset of the same registers
  localparam logic [2:0][7:0] IO_CTRL_IND_PAGE = {8'h9e, 8'h5e, 8'h1e};
  localparam logic [7:0] IO_CTRL_IND_OFFSET = 8'h01;
  localparam logic [7:0] IO_CTRL_RESET      = 8'h00;
  localparam logic [7:0] IO_CTRL_WR_MASK    = 8'h7f;
  localparam int CLK_INV_BIT    = 1;
  localparam int CLK_LEVEL_BIT  = 7;
  // lanes of the add-bus byte reused as line data and line clocks
  localparam int LINE_DATA_LANE = 2;
  localparam int LINE_CLK_LANE  = 5;
  localparam int BYTE_MSB_LANE  = 7;
  localparam int FIFO_DEPTH     = 32;
  localparam int FIFO_AW        = 5;
endpackage

/* File: add_bus_line_input_mux.sv */
/*
  shared-pin input logic of the channel 0 add bus: byte capture on the
  add-bus clock into a dual-clock fifo, or line data and line clocks for
  line channels 0, 4 and 8 sampled in the system clock domain, plus the
  three i/o control registers on the 8-bit parallel register port.
  assumes register port, bus enable and sts-1 mode inputs are synchronous
  to i_clk, and that i_clk is well above the recovered line clock rates.
*/
// Overview of operation
// - bus enable picks add-bus byte role or line-interface role for pins.
// - enabled bus captures every lane on falling add-bus clock edge.
// - lane 7 is the most significant bit of each captured byte.
// - disabled bus: lanes 3 and 4 carry line data for channels 4, 8.
// - disabled bus: lanes 5-7 are line clocks of channels 0, 4, 8.
// - line data is latched on the falling line clock edge by default.
// - clock invert bit 1 set in ds3/e3 mode selects rising-edge sampling.
// - sts-1 mode always samples on the falling line clock edge.
// - channel 0 control register at indirect 0x1e,0x01 and direct 0x1f01.
// - channel 8 control register at indirect 0x9e,0x01, direct 0x9f01.

module add_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic             i_rstn,
  input  wire logic             i_wr_clk,
  input  wire logic             i_wr_valid,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_wr_ready,
  input  wire logic             i_rd_clk,
  output logic                  o_rd_valid,
  output logic [WIDTH-1:0]      o_rd_data,
  input  wire logic             i_rd_ready
);
  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] rq1;
    logic [AW:0] rq2;
    logic        ready;
  } wr_s;
  typedef struct packed {
    logic [AW:0]      bin;
    logic [AW:0]      gray;
    logic [AW:0]      wq1;
    logic [AW:0]      wq2;
    logic             valid;
    logic [WIDTH-1:0] data;
  } rd_s;

  logic [WIDTH-1:0] mem [DEPTH];
  wr_s              w_ff;
  wr_s              nxt_w;
  rd_s              r_ff;
  rd_s              nxt_r;
  logic             push;
  logic             pop;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  assign push = i_wr_valid & w_ff.ready;

  // write side runs on the falling edge of the write clock
  always_comb begin
    nxt_w       = w_ff;
    nxt_w.rq1   = r_ff.gray;
    nxt_w.rq2   = w_ff.rq1;
    nxt_w.bin   = w_ff.bin + {{AW{1'b0}}, push};
    nxt_w.gray  = to_gray(nxt_w.bin);
    nxt_w.ready = nxt_w.gray !=
                  {~w_ff.rq2[AW:AW-1], w_ff.rq2[AW-2:0]};
  end

  always_ff @(negedge i_wr_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      w_ff <= '0;
    end else begin
      w_ff <= nxt_w;
    end
  end

  always_ff @(negedge i_wr_clk) begin
    if (push) begin
      mem[w_ff.bin[AW-1:0]] <= i_wr_data;
    end
  end

  assign pop = (r_ff.gray != r_ff.wq2) & (!r_ff.valid | i_rd_ready);

  always_comb begin
    nxt_r      = r_ff;
    nxt_r.wq1  = w_ff.gray;
    nxt_r.wq2  = r_ff.wq1;
    nxt_r.bin  = r_ff.bin + {{AW{1'b0}}, pop};
    nxt_r.gray = to_gray(nxt_r.bin);
    if (pop) begin
      nxt_r.valid = 1'b1;
      nxt_r.data  = mem[r_ff.bin[AW-1:0]];
    end else if (i_rd_ready) begin
      nxt_r.valid = 1'b0;
    end
  end

  always_ff @(posedge i_rd_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign o_wr_ready = w_ff.ready;
  assign o_rd_valid = r_ff.valid;
  assign o_rd_data  = r_ff.data;

  // a full fifo must leave its write pointer alone
  full_hold_a: assert property (@(negedge i_wr_clk) disable iff (!i_rstn)
    !w_ff.ready |=> w_ff.bin == $past(w_ff.bin))
    else $error("fifo write pointer moved while full");
endmodule

module add_bus_line_input_mux
  import add_bus_mux_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  input  wire logic              i_add_bus_clock_ch0,
  input  wire logic [BYTE_W-1:0] i_add_bus_byte_ch0,
  input  wire logic              i_bus_enable,
  input  wire logic [N_LINE-1:0] i_sts1_mode,
  input  wire logic              i_indirect,
  input  wire logic [15:0]       i_addr,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  input  wire logic [7:0]        i_wdata,
  output logic [7:0]             o_rdata,
  output logic                   o_add_bus_ready,
  output logic                   o_byte_valid,
  output logic [BYTE_W-1:0]      o_byte_data,
  input  wire logic              i_byte_ready,
  output logic [N_LINE-1:0]      o_line_strobe,
  output logic [N_LINE-1:0]      o_line_data
);
  typedef struct packed {
    logic [N_LINE-1:0][7:0] ctrl;
    logic [7:0]             rdata;
    logic [N_LINE-1:0]      dat1;
    logic [N_LINE-1:0]      dat2;
    logic [N_LINE-1:0]      clk1;
    logic [N_LINE-1:0]      clk2;
    logic [N_LINE-1:0]      clk3;
    logic [N_LINE-1:0]      strobe;
    logic [N_LINE-1:0]      data;
  } st_s;
  typedef struct packed {
    logic en1;
    logic en2;
  } add_s;

  st_s  st_ff;
  st_s  nxt_st;
  add_s add_ff;
  add_s nxt_add;

  // add-bus side: bus enable crosses as a level into the add clock domain
  always_comb begin
    nxt_add     = add_ff;
    nxt_add.en1 = i_bus_enable;
    nxt_add.en2 = add_ff.en1;
  end

  always_ff @(negedge i_add_bus_clock_ch0 or negedge i_rstn) begin
    if (!i_rstn) begin
      add_ff <= '0;
    end else begin
      add_ff <= nxt_add;
    end
  end

  // the byte is taken on the falling add clock edge, lane 7 as msb
  add_byte_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .i_rstn     (i_rstn),
    .i_wr_clk   (i_add_bus_clock_ch0),
    .i_wr_valid (add_ff.en2),
    .i_wr_data  (i_add_bus_byte_ch0[BYTE_MSB_LANE:0]),
    .o_wr_ready (o_add_bus_ready),
    .i_rd_clk   (i_clk),
    .o_rd_valid (o_byte_valid),
    .o_rd_data  (o_byte_data),
    .i_rd_ready (i_byte_ready)
  );

  always_comb begin
    logic hit;
    logic rise;
    logic fall;
    logic inv;
    hit          = 1'b0;
    rise         = 1'b0;
    fall         = 1'b0;
    inv          = 1'b0;
    nxt_st       = st_ff;
    // line data and clocks pass two flops before any logic looks at them
    nxt_st.dat1  = i_add_bus_byte_ch0[LINE_DATA_LANE +: N_LINE];
    nxt_st.clk1  = i_add_bus_byte_ch0[LINE_CLK_LANE +: N_LINE];
    nxt_st.dat2  = st_ff.dat1;
    nxt_st.clk2  = st_ff.clk1;
    nxt_st.clk3  = st_ff.clk2;
    if (i_rd) begin
      nxt_st.rdata = 8'h00;
    end
    for (int c = 0; c < N_LINE; c++) begin
      hit = i_addr[7:0] == IO_CTRL_IND_OFFSET &&
            i_addr[15:8] == (i_indirect ? IO_CTRL_IND_PAGE[c]
                                        : IO_CTRL_DIRECT[c][15:8]);
      if (i_wr && hit) begin
        nxt_st.ctrl[c] = i_wdata & IO_CTRL_WR_MASK;
      end
      if (i_rd && hit) begin
        nxt_st.rdata = st_ff.ctrl[c];
        nxt_st.rdata[CLK_LEVEL_BIT] = st_ff.clk2[c];
      end
      rise = st_ff.clk2[c] & ~st_ff.clk3[c];
      fall = ~st_ff.clk2[c] & st_ff.clk3[c];
      inv  = st_ff.ctrl[c][CLK_INV_BIT] & ~i_sts1_mode[c];
      nxt_st.strobe[c] = ~i_bus_enable & (inv ? rise : fall);
      if (nxt_st.strobe[c]) begin
        nxt_st.data[c] = st_ff.dat2[c];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_ff      <= '0;
      st_ff.ctrl <= {N_LINE{IO_CTRL_RESET}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_rdata       = st_ff.rdata;
  assign o_line_strobe = st_ff.strobe;
  assign o_line_data   = st_ff.data;

  sequence line_fall_s(int c);
    st_ff.clk3[c] && !st_ff.clk2[c];
  endsequence
  sequence line_rise_s(int c);
    !st_ff.clk3[c] && st_ff.clk2[c];
  endsequence

  ch0_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_wr && !i_indirect && i_addr == IO_CTRL_DIRECT[0]) |=>
    st_ff.ctrl[0] == ($past(i_wdata) & IO_CTRL_WR_MASK))
    else $error("ch0 control register missed a direct write");
  ch8_ind_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_wr && i_indirect &&
     i_addr == {IO_CTRL_IND_PAGE[2], IO_CTRL_IND_OFFSET}) |=>
    st_ff.ctrl[2] == ($past(i_wdata) & IO_CTRL_WR_MASK))
    else $error("ch8 control register missed an indirect write");
  bus_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_bus_enable |=> o_line_strobe == 3'h0)
    else $error("line strobe while add bus enabled");
  fall_default_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (line_fall_s(0) and (!i_bus_enable &&
     !st_ff.ctrl[0][CLK_INV_BIT])) |=> o_line_strobe[0])
    else $error("ch0 falling edge not sampled");
  rise_inv_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (line_rise_s(1) and (!i_bus_enable && !i_sts1_mode[1] &&
     st_ff.ctrl[1][CLK_INV_BIT])) |=> o_line_strobe[1])
    else $error("ch4 inverted clock not sampled on rise");
  sts1_fall_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (line_rise_s(2) and i_sts1_mode[2]) |=> !o_line_strobe[2])
    else $error("sts-1 channel sampled on rising edge");
  lane_data_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_line_strobe[1] |-> o_line_data[1] == $past(st_ff.dat2[1]))
    else $error("ch4 data not taken from its data lane");
  clock_lane_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_line_strobe[2] |-> $past(st_ff.clk2[2]) != $past(st_ff.clk3[2]))
    else $error("ch8 strobe without an edge on its clock lane");

  // register reads: unmapped reads give zero, indirect reads at 0x1e,0x01 hit ch0
  rdata_clear_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_rd && i_addr[7:0] != IO_CTRL_IND_OFFSET) |=> o_rdata == 8'h00)
    else $error("unmapped read returned nonzero data");
  ch0_ind_read_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_rd && i_indirect &&
     i_addr == {IO_CTRL_IND_PAGE[0], IO_CTRL_IND_OFFSET}) |=>
    o_rdata[6:0] == $past(st_ff.ctrl[0][6:0]))
    else $error("ch0 control register missed an indirect read");
  sts1_take_fall_a: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (line_fall_s(2) and (!i_bus_enable && i_sts1_mode[2])) |=>
    o_line_strobe[2])
    else $error("sts-1 channel missed its falling edge");
endmodule

/* File: add_bus_source.sv */
/* far-side model: add-bus byte source and three line units on the
   eight shared pins. assumes the bench calls its tasks. */
module add_bus_source (
  output logic       o_clk,
  output logic [7:0] o_pins
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_clk  = 1'b0;
    o_pins = 8'h00;
  end
  // clock stands still between bytes; lanes flip once released
  task automatic send_byte(input logic [7:0] b);
    o_clk  = 1'b1;
    o_pins = b;
    #15 o_clk = 1'b0;
    #7 o_pins = ~b;
    #8;
  endtask
  // a is steady at the rising edge, b at the falling edge
  task automatic line_bit(input int c, input logic a, input logic b);
    o_pins[2+c] = a;
    #80 o_pins[5+c] = 1'b1;
    #80 o_pins[2+c] = b;
    #80 o_pins[5+c] = 1'b0;
    #80 o_pins[2+c] = ~b;
  endtask
endmodule

/* File: tb_add_bus_line_input_mux.sv */
/* bench: registers, line sampling edges, add-bus fifo.
   assumes add_bus_source drives the shared pins. */
module tb_add_bus_line_input_mux
  import add_bus_mux_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_clk, i_rstn, i_bus_enable, i_indirect, i_wr, i_rd;
  logic        add_clk, o_add_bus_ready, o_byte_valid, i_byte_ready;
  logic [7:0]  pins, i_wdata, o_rdata, o_byte_data;
  logic [15:0] i_addr;
  logic [2:0]  i_sts1_mode, o_line_strobe, o_line_data, s_bits, s_data;
  int          err_count, checks_done, cycles, s_cnt;

  add_bus_source pm (.o_clk(add_clk), .o_pins(pins));
  add_bus_line_input_mux dut (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_add_bus_clock_ch0(add_clk),
    .i_add_bus_byte_ch0(pins), .i_bus_enable(i_bus_enable),
    .i_sts1_mode(i_sts1_mode), .i_indirect(i_indirect),
    .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata),
    .o_rdata(o_rdata), .o_add_bus_ready(o_add_bus_ready),
    .o_byte_valid(o_byte_valid), .o_byte_data(o_byte_data),
    .i_byte_ready(i_byte_ready), .o_line_strobe(o_line_strobe),
    .o_line_data(o_line_data));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  // strobes are read mid-cycle, where they stand settled
  always @(negedge i_clk) begin
    cycles++;
    if (o_line_strobe != 3'b000) begin
      s_cnt++;
      s_bits = o_line_strobe;
      s_data = o_line_data;
    end
    if (cycles == 5000) begin
      err_count++;
      stop_test();
    end
  end

  function automatic logic [7:0] pat(input int k);
    return 8'(k * 37 + 129);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one strobe, then wait until the read answer has landed
  task automatic reg_op(input logic w, input logic ind,
                        input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk) #1;
    i_wr = w;
    i_rd = !w;
    i_indirect = ind;
    i_addr = a;
    i_wdata = d;
    @(posedge i_clk) #1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    @(posedge i_clk) #1;
  endtask

  task automatic t_regs();
    for (int c = 0; c < 3; c++) begin
      reg_op(1'b0, 1'b0, IO_CTRL_DIRECT[c], 8'h00);
      chk(o_rdata, IO_CTRL_RESET);
    end
    reg_op(1'b1, 1'b0, 16'h1f01, 8'h02);
    reg_op(1'b0, 1'b1, 16'h1e01, 8'h00);
    chk(o_rdata, 8'h02);
    reg_op(1'b1, 1'b1, 16'h9e01, 8'hff);
    reg_op(1'b0, 1'b0, 16'h9f01, 8'h00);
    chk(o_rdata, 8'h7f);
    reg_op(1'b0, 1'b0, 16'h1f02, 8'h00);
    chk(o_rdata, 8'h00);
  endtask

  // per channel: default, inverted, inverted but sts-1
  task automatic t_line(input logic en, input int lim);
    logic a;
    logic e;
    logic [2:0] cb;
    i_bus_enable = en;
    for (int c = 0; c < lim; c++) begin
      for (int m = 0; m < 3; m++) begin
        reg_op(1'b1, 1'b0, IO_CTRL_DIRECT[c], (m != 0) ? 8'h02 : 8'h00);
        i_sts1_mode[c] = (m == 2);
        a = m[0] ^ c[0];
        e = (m == 1) ? a : !a;
        cb = 3'b001 << c;
        s_cnt = 0;
        s_bits = 3'b000;
        s_data = 3'b000;
        pm.line_bit(c, a, !a);
        repeat (6) @(posedge i_clk);
        #1;
        chk(8'(s_cnt), en ? 8'h00 : 8'h01);
        chk({2'b0, s_bits, s_data & s_bits},
            en ? 8'h00 : {2'b0, cb, e ? cb : 3'b000});
      end
    end
  endtask

  // fill past capacity with the sink stalled, then drain in order;
  // the output stage holds one byte beyond the 32 stored ones
  task automatic t_fifo();
    int n;
    i_bus_enable = 1'b1;
    pm.send_byte(8'h00);
    pm.send_byte(8'h00);
    for (int k = 0; k < FIFO_DEPTH + 2; k++)
      pm.send_byte(pat(k));
    chk({7'h0, o_add_bus_ready}, 8'h00);
    for (int k = 0; k < FIFO_DEPTH + 1; k++) begin
      n = 0;
      while (o_byte_valid !== 1'b1 && n < 20) begin
        @(posedge i_clk) #1;
        n++;
      end
      chk(o_byte_data, pat(k));
      i_byte_ready = 1'b1;
      @(posedge i_clk) #1;
      i_byte_ready = 1'b0;
    end
    repeat (10) @(posedge i_clk);
    chk({7'h0, o_byte_valid}, 8'h00);
  endtask

  task automatic stop_test();
    if (err_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    {i_rstn, i_bus_enable, i_indirect, i_wr, i_rd, i_byte_ready} = 6'h0;
    i_sts1_mode = 3'b000;
    i_addr = 16'h0000;
    i_wdata = 8'h00;
    {err_count, checks_done, cycles, s_cnt} = '0;
    // the add clock must tick during reset too; lanes end at zero
    fork
      repeat (2) @(posedge i_clk);
      repeat (2) pm.send_byte(8'hff);
    join
    #1 i_rstn = 1'b1;
    t_regs();
    t_line(1'b0, 3);
    t_line(1'b1, 1);
    t_fifo();
    stop_test();
  end
endmodule
